/* File: rtl/cbp_unit.sv */
// Purpose: compare and special bit processing instructions
// Assumes: sequencer issues one instruction per command write
// Notes: each command executes in the bus cycle that acknowledges it
`timescale 1ns/1ps
`default_nettype none
module cbp_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rung_o,
    output logic carry_o
);
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] cmd_reg;
    logic [31:0] cmd_word;
    logic rung_reg;
    logic carry_reg;
    logic [15:0] dev_reg;
    logic [15:0] cnt_reg;
    logic cnt_prev_reg;
    logic [15:0] file_reg [cbp_pkg::NREG];
    logic [cbp_pkg::FBITS-1:0] flat;
    logic [cbp_pkg::FBITS-1:0] file_next;
    logic wr_en;
    logic exec;
    cbp_pkg::cbp_cmd_t cmd;
    logic [3:0] a1;
    logic [3:0] b1;
    logic [15:0] wa;
    logic [15:0] wb;
    logic [31:0] da;
    logic [31:0] db;
    logic lt_s, lt_u, lt_d, eq_w, eq_d;
    logic cmp_on;
    logic is_cmp;
    logic [3:0] n_eff;
    logic [8:0] span;
    logic [7:0] sel_bit;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // relation from less-than and equal flags
    function automatic logic rel(input logic [2:0] code, input logic lt,
                                 input logic eq);
        logic r;
        case (code)
            cbp_pkg::CBP_GT: r = !lt && !eq;
            cbp_pkg::CBP_GE: r = !lt;
            cbp_pkg::CBP_EQ: r = eq;
            cbp_pkg::CBP_NE: r = !eq;
            cbp_pkg::CBP_LT: r = lt;
            cbp_pkg::CBP_LE: r = lt || eq;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // write commits on the edge where the master sees ack
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign exec = wr_en && (wb_adr_i == cbp_pkg::ADR_CMD);
    assign cmd_word = merge(cmd_reg, wb_dat_i, wb_sel_i);
    assign cmd = cbp_pkg::cbp_cmd_t'(cmd_word[23:0]);
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign rung_o = rung_reg;
    assign carry_o = carry_reg;

    // flatten the register file into one bit file
    genvar gi;
    generate
        for (gi = 0; gi < cbp_pkg::NREG; gi++) begin : g_flat
            assign flat[gi*16 +: 16] = file_reg[gi];
        end
    endgenerate

    assign a1 = cmd.a + 4'h1;
    assign b1 = cmd.b + 4'h1;
    assign wa = file_reg[cmd.a];
    assign wb = file_reg[cmd.b];
    assign da = {file_reg[a1], wa};
    assign db = {file_reg[b1], wb};

    // signed and unsigned views, upper register is high half
    assign lt_s = $signed(wa) < $signed(wb);
    assign lt_u = wa < wb;
    assign lt_d = $signed(da) < $signed(db);
    assign eq_w = wa == wb;
    assign eq_d = da == db;

    always_comb begin
        is_cmp = 1'b1;
        cmp_on = 1'b0;
        if (cmd.op >= cbp_pkg::OP_CMP_S && cmd.op < cbp_pkg::OP_CMP_D) begin
            cmp_on = rel(3'(cmd.op - cbp_pkg::OP_CMP_S), lt_s, eq_w);
        end else if (cmd.op >= cbp_pkg::OP_CMP_D &&
                     cmd.op < cbp_pkg::OP_CMP_U) begin
            cmp_on = rel(3'(cmd.op - cbp_pkg::OP_CMP_D), lt_d, eq_d);
        end else if (cmd.op >= cbp_pkg::OP_CMP_U &&
                     cmd.op < cbp_pkg::OP_SET) begin
            cmp_on = rel(3'(cmd.op - cbp_pkg::OP_CMP_U), lt_u, eq_w);
        end else begin
            is_cmp = 1'b0;
        end
    end

    // file size clamped to 2^8 bits, the whole register file
    assign n_eff = (cmd.n > cbp_pkg::N_MAX) ? cbp_pkg::N_MAX : cmd.n;
    assign span = 9'h001 << n_eff;
    assign sel_bit = wa[7:0] & 8'(span - 9'h001);

    // next contents of the register file
    always_comb begin
        logic [7:0] base;
        logic [7:0] pos;
        logic found;
        logic [4:0] ones;
        base = 8'({cmd.b, 4'h0});
        pos = 8'h00;
        found = 1'b0;
        ones = 5'h00;
        file_next = flat;
        if (wr_en && wb_adr_i[7:6] == cbp_pkg::ADR_FILE_HI) begin
            file_next[wb_adr_i[5:2]*16 +: 16] =
                16'(merge({16'h0000, flat[wb_adr_i[5:2]*16 +: 16]},
                          wb_dat_i, wb_sel_i));
        end else if (exec) begin
            case (cmd.op)
                cbp_pkg::OP_SET: begin
                    if (cmd.is_reg) begin
                        file_next[cmd.a*16 +: 16] = cbp_pkg::ALL_ONES;
                    end
                end
                cbp_pkg::OP_RST: begin
                    if (cmd.is_reg) begin
                        file_next[cmd.a*16 +: 16] = cbp_pkg::RST_WORD;
                    end
                end
                cbp_pkg::OP_TOP_BIT: begin
                    base = 8'({cmd.a, 4'h0});
                    for (int k = 0; k < cbp_pkg::FBITS; k++) begin
                        if (9'(k) < span && flat[8'(base + 8'(k))]) begin
                            pos = 8'(k);
                            found = 1'b1;
                        end
                    end
                    // an empty file leaves B untouched
                    if (found) begin
                        file_next[cmd.b*16 +: 16] = {8'h00, pos};
                    end
                end
                cbp_pkg::OP_ONE_HOT: begin
                    for (int k = 0; k < cbp_pkg::FBITS; k++) begin
                        if (9'(k) < span) begin
                            file_next[8'(base + 8'(k))] = 8'(k) == sel_bit;
                        end
                    end
                end
                cbp_pkg::OP_ONES: begin
                    for (int k = 0; k < 16; k++) begin
                        ones = ones + {4'h0, wa[k]};
                    end
                    file_next[cmd.b*16 +: 16] = {11'h000, ones};
                end
                default: begin
                end
            endcase
        end
    end

    // register file storage
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < cbp_pkg::NREG; i++) begin
            if (rst_i) begin
                file_reg[i] <= cbp_pkg::RST_WORD;
            end else begin
                file_reg[i] <= file_next[i*16 +: 16];
            end
        end
    end

    // wishbone ack, one wait state, drops after each answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    // read data sampled with the ack, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= cbp_pkg::RST_CMD;
        end else if (wb_adr_i == cbp_pkg::ADR_CMD) begin
            dat_reg <= cmd_reg;
        end else if (wb_adr_i == cbp_pkg::ADR_STAT) begin
            dat_reg <= {30'h0000_0000, carry_reg, rung_reg};
        end else if (wb_adr_i == cbp_pkg::ADR_DEV) begin
            dat_reg <= {16'h0000, dev_reg};
        end else if (wb_adr_i == cbp_pkg::ADR_CNT) begin
            dat_reg <= {16'h0000, cnt_reg};
        end else if (wb_adr_i[7:6] == cbp_pkg::ADR_FILE_HI) begin
            dat_reg <= {16'h0000, file_reg[wb_adr_i[5:2]]};
        end else begin
            dat_reg <= cbp_pkg::RST_CMD;
        end
    end

    // last command kept for readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= cbp_pkg::RST_CMD;
        end else if (exec) begin
            cmd_reg <= {8'h00, cmd_word[23:0]};
        end
    end

    // rung follows only the latest compare
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rung_reg <= 1'b0;
        end else if (exec && is_cmp) begin
            rung_reg <= cmp_on;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_reg <= 1'b0;
        end else if (exec && cmd.op == cbp_pkg::OP_CARRY_ON) begin
            carry_reg <= 1'b1;
        end else if (exec && cmd.op == cbp_pkg::OP_CARRY_OFF) begin
            carry_reg <= 1'b0;
        end
    end

    // bit devices: bus, set/reset and latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_reg <= cbp_pkg::RST_WORD;
        end else if (wr_en && wb_adr_i == cbp_pkg::ADR_DEV) begin
            dev_reg <= 16'(merge({16'h0000, dev_reg}, wb_dat_i, wb_sel_i));
        end else if (exec && !cmd.is_reg && cmd.op == cbp_pkg::OP_SET) begin
            dev_reg[cmd.a] <= 1'b1;
        end else if (exec && !cmd.is_reg && cmd.op == cbp_pkg::OP_RST) begin
            dev_reg[cmd.a] <= 1'b0;
        end else if (exec && cmd.op == cbp_pkg::OP_LATCH) begin
            if (cmd.in_r) begin
                dev_reg[cmd.a] <= 1'b0;
            end else if (cmd.in_s) begin
                dev_reg[cmd.a] <= 1'b1;
            end
        end
    end

    // count input is seen only when the instruction runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_prev_reg <= 1'b0;
        end else if (exec && cmd.op == cbp_pkg::OP_UPDN) begin
            cnt_prev_reg <= cmd.in_r;
        end
    end

    // up/down counter, wraps at 16 bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= cbp_pkg::RST_WORD;
        end else if (wr_en && wb_adr_i == cbp_pkg::ADR_CNT) begin
            cnt_reg <= 16'(merge({16'h0000, cnt_reg}, wb_dat_i, wb_sel_i));
        end else if (exec && cmd.op == cbp_pkg::OP_UPDN && cmd.in_s &&
                     cmd.in_r && !cnt_prev_reg) begin
            // one step per rising count input
            cnt_reg <= cmd.up_sel ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_op(logic [7:0] o);
        exec && cmd.op == o;
    endsequence

    property p_cmp_s_gt;
        s_op(cbp_pkg::OP_CMP_S) |=> rung_reg == ($past(!lt_s && !eq_w));
    endproperty
    a_cmp_s_gt: assert property (p_cmp_s_gt)
        else $error("signed greater compare wrong");

    property p_cmp_d_eq;
        s_op(cbp_pkg::OP_CMP_D + 8'h02) |=> rung_reg == $past(da == db);
    endproperty
    a_cmp_d_eq: assert property (p_cmp_d_eq)
        else $error("double-word equal compare wrong");

    property p_cmp_u_lt;
        s_op(cbp_pkg::OP_CMP_U + 8'h04) |=> rung_reg == $past(wa < wb);
    endproperty
    a_cmp_u_lt: assert property (p_cmp_u_lt)
        else $error("unsigned less compare wrong");

    property p_set_reg;
        s_op(cbp_pkg::OP_SET) ##0 cmd.is_reg |=>
            file_reg[$past(cmd.a)] == cbp_pkg::ALL_ONES;
    endproperty
    a_set_reg: assert property (p_set_reg)
        else $error("register set did not give all ones");

    property p_rst_dev;
        s_op(cbp_pkg::OP_RST) ##0 !cmd.is_reg |=> !dev_reg[$past(cmd.a)];
    endproperty
    a_rst_dev: assert property (p_rst_dev)
        else $error("device reset did not turn it off");

    property p_carry;
        s_op(cbp_pkg::OP_CARRY_ON) |=> carry_o;
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry not forced on");

    property p_carry_off;
        s_op(cbp_pkg::OP_CARRY_OFF) |=> !carry_o;
    endproperty
    a_carry_off: assert property (p_carry_off)
        else $error("carry not forced off");

    property p_latch;
        s_op(cbp_pkg::OP_LATCH) ##0 cmd.in_r |=> !dev_reg[$past(cmd.a)];
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch reset did not win");

    property p_cnt_hold;
        !(exec && cmd.in_s) && !(wr_en && wb_adr_i == cbp_pkg::ADR_CNT)
            |=> $stable(cnt_reg);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("counter moved while not enabled");

    property p_cnt_up;
        s_op(cbp_pkg::OP_UPDN) ##0 cmd.in_s && cmd.in_r && cmd.up_sel &&
            !cnt_prev_reg |=> cnt_reg == $past(cnt_reg) + 16'h0001;
    endproperty
    a_cnt_up: assert property (p_cnt_up)
        else $error("counter did not count up");
endmodule // cbp_unit
`default_nettype wire

/* File: shared/cbp_pkg.sv */
// Purpose: constants and types of the compare and bit processing unit
// Assumes: 16-bit data registers, classic wishbone with 32-bit data
// Notes: opcodes are instruction numbers, carry opcodes chosen locally
`default_nettype none
package cbp_pkg;
    // register file geometry
    localparam int DW = 16;
    localparam int NREG = 16;
    localparam int FBITS = DW * NREG;
    // byte offsets on the bus
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_DEV = 8'h08;
    localparam logic [7:0] ADR_CNT = 8'h0c;
    localparam logic [1:0] ADR_FILE_HI = 2'h1;
    // status bit positions
    localparam int STAT_RUNG = 0;
    localparam int STAT_CARRY = 1;
    // reset values and constants
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_CMD = 32'h0000_0000;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [3:0] N_MAX = 4'h8;
    // opcodes
    localparam logic [7:0] OP_CMP_S = 8'h60;
    localparam logic [7:0] OP_CMP_D = 8'h66;
    localparam logic [7:0] OP_CMP_U = 8'h6c;
    localparam logic [7:0] OP_SET = 8'h72;
    localparam logic [7:0] OP_RST = 8'h73;
    localparam logic [7:0] OP_CARRY_ON = 8'h74;
    localparam logic [7:0] OP_CARRY_OFF = 8'h75;
    localparam logic [7:0] OP_TOP_BIT = 8'h78;
    localparam logic [7:0] OP_ONE_HOT = 8'h79;
    localparam logic [7:0] OP_ONES = 8'h7a;
    localparam logic [7:0] OP_LATCH = 8'h93;
    localparam logic [7:0] OP_UPDN = 8'h95;
    // relation codes, offset from a compare family base
    typedef enum logic [2:0] {
        CBP_GT = 3'h0, CBP_GE = 3'h1, CBP_EQ = 3'h2,
        CBP_NE = 3'h3, CBP_LT = 3'h4, CBP_LE = 3'h5
    } cbp_rel_t;
    // one instruction as written to the command word
    typedef struct packed {
        logic up_sel;
        logic in_r;
        logic in_s;
        logic is_reg;
        logic [3:0] n;
        logic [3:0] b;
        logic [3:0] a;
        logic [7:0] op;
    } cbp_cmd_t;
endpackage
`default_nettype wire

/* File: sim/cbp_seq_model.sv */
// Purpose: scan sequencer model issuing instructions over wishbone
// Assumes: classic single cycles, slave answers after one or more waits
// Notes: no wait limit here, the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module cbp_seq_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i;
        // released address and data lines show junk so stale values are never trusted
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule // cbp_seq_model
`default_nettype wire

/* File: sim/cbp_unit_tb.sv */
// Purpose: self-checking bench of the compare and bit processing unit
// Assumes: command executes at the acking edge of its write
// Notes: compares, latch and counter steps run from tables, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module cbp_unit_tb;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [2:0][5:0] e;
    } cbp_row_t;
    logic clk_i;
    logic rst_i;
    logic cyc, stb, we, ack, rung, carry;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int n_errors = 0;
    int n_compared = 0;
    // relation masks per family: unsigned, double, signed
    cbp_row_t rows [3] = '{
        {32'h0001_ffff, 32'h0000_0001, {6'h0b, 6'h0b, 6'h38}},
        {32'h8000_8000, 32'h8000_8000, {6'h26, 6'h26, 6'h26}},
        {32'h8000_0000, 32'h7fff_0000, {6'h26, 6'h38, 6'h26}}};
    logic [7:0] base [3] = '{cbp_pkg::OP_CMP_S, cbp_pkg::OP_CMP_D,
        cbp_pkg::OP_CMP_U};
    // latch steps {set, reset, expected}
    logic [2:0] lat [6] = '{3'h5, 3'h6, 3'h0, 3'h5, 3'h1, 3'h2};
    // counter steps {enable, count, up} and expected count
    logic [2:0] cin [14] = '{3'h5, 3'h7, 3'h7, 3'h5, 3'h7, 3'h0, 3'h2,
        3'h6, 3'h4, 3'h6, 3'h4, 3'h6, 3'h4, 3'h6};
    logic [15:0] cexp [14] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001,
        16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0001,
        16'h0001, 16'h0000, 16'h0000, 16'hffff};

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    cbp_unit DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rung_o(rung), .carry_o(carry));

    cbp_seq_model SEQ (
        .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // bus helpers
    function automatic logic [7:0] fa(input logic [3:0] i);
        return 8'h40 + {2'b00, i, 2'b00};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        SEQ.xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        SEQ.xfer(1'b0, a, 32'h0000_0000, x);
    endtask
    // flags are {up, count or reset, enable or set, is register}
    task automatic cmd(input logic [7:0] op, input logic [3:0] a,
                       input logic [3:0] b, input logic [3:0] n,
                       input logic [3:0] f);
        cbp_pkg::cbp_cmd_t c;
        c = {f, n, b, a, op};
        wr(cbp_pkg::ADR_CMD, {8'h00, c});
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        results();
    end

    initial begin
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // flags and counter idle after reset
        chk({30'h0, carry, rung}, 32'h0000_0000);
        rd(cbp_pkg::ADR_CNT, q);
        chk(q, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(fa(4'h0), {16'h0000, rows[i].a[15:0]});
            wr(fa(4'h1), {16'h0000, rows[i].a[31:16]});
            wr(fa(4'h2), {16'h0000, rows[i].b[15:0]});
            wr(fa(4'h3), {16'h0000, rows[i].b[31:16]});
            for (int f = 0; f < 3; f++) begin
                for (int r = 0; r < 6; r++) begin
                    cmd(base[f] + 8'(r), 4'h0, 4'h2, 4'h0, 4'h0);
                    chk({31'h0, rung}, {31'h0, rows[i].e[f][r]});
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            cmd(k < 2 ? cbp_pkg::OP_CARRY_ON : cbp_pkg::OP_CARRY_OFF,
                4'h0, 4'h0, 4'h0, 4'h0);
            rd(cbp_pkg::ADR_STAT, q);
            chk({31'h0, q[1]}, {31'h0, k < 2});
            chk({31'h0, carry}, {31'h0, k < 2});
        end
        // set and reset, register and device
        cmd(cbp_pkg::OP_SET, 4'h5, 4'h0, 4'h0, 4'h1);
        rd(fa(4'h5), q);
        chk(q, 32'h0000_ffff);
        cmd(cbp_pkg::OP_SET, 4'h3, 4'h0, 4'h0, 4'h0);
        rd(cbp_pkg::ADR_DEV, q);
        chk(q, 32'h0000_0008);
        cmd(cbp_pkg::OP_RST, 4'h5, 4'h0, 4'h0, 4'h1);
        rd(fa(4'h5), q);
        chk(q, 32'h0000_0000);
        cmd(cbp_pkg::OP_RST, 4'h3, 4'h0, 4'h0, 4'h0);
        rd(cbp_pkg::ADR_DEV, q);
        chk(q, 32'h0000_0000);
        // top bit over two registers, reg 7 outside file
        wr(fa(4'h4), 32'h0000_0001);
        wr(fa(4'h5), 32'h0000_0240);
        wr(fa(4'h7), 32'h0000_8000);
        cmd(cbp_pkg::OP_TOP_BIT, 4'h4, 4'h6, 4'h5, 4'h0);
        rd(fa(4'h6), q);
        chk(q, 32'h0000_0019);
        // one hot, reg 10 holds 0x33, low 5 bits pick bit 19
        wr(fa(4'h8), 32'h0000_ffff);
        wr(fa(4'h9), 32'h0000_ffff);
        wr(fa(4'ha), 32'h0000_0033);
        cmd(cbp_pkg::OP_ONE_HOT, 4'ha, 4'h8, 4'h5, 4'h0);
        rd(fa(4'h8), q);
        chk(q, 32'h0000_0000);
        rd(fa(4'h9), q);
        chk(q, 32'h0000_0008);
        rd(fa(4'ha), q);
        chk(q, 32'h0000_0033);
        wr(fa(4'hb), 32'h0000_f0f1);
        cmd(cbp_pkg::OP_ONES, 4'hb, 4'hc, 4'h0, 4'h0);
        rd(fa(4'hc), q);
        chk(q, 32'h0000_0009);
        foreach (lat[i]) begin
            cmd(cbp_pkg::OP_LATCH, 4'h2, 4'h0, 4'h0,
                {1'b0, lat[i][1], lat[i][2], 1'b0});
            rd(cbp_pkg::ADR_DEV, q);
            chk({31'h0, q[2]}, {31'h0, lat[i][0]});
        end
        foreach (cin[i]) begin
            cmd(cbp_pkg::OP_UPDN, 4'h0, 4'h0, 4'h0,
                {cin[i][0], cin[i][1], cin[i][2], 1'b0});
            rd(cbp_pkg::ADR_CNT, q);
            chk(q, {16'h0000, cexp[i]});
        end
        // unmapped place reads zero, write dropped
        wr(8'h20, 32'h1234_5678);
        rd(8'h20, q);
        chk(q, 32'h0000_0000);
        // bus writes to devices and counter, upper lanes read zero
        wr(cbp_pkg::ADR_DEV, 32'hffff_a5a5);
        rd(cbp_pkg::ADR_DEV, q);
        chk(q, 32'h0000_a5a5);
        wr(cbp_pkg::ADR_CNT, 32'h0000_5a5a);
        rd(cbp_pkg::ADR_CNT, q);
        chk(q, 32'h0000_5a5a);
        cmd(cbp_pkg::OP_CARRY_ON, 4'h0, 4'h0, 4'h0, 4'h0);
        // mid-run reset clears flags, devices, counter and file
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({30'h0, carry, rung}, 32'h0000_0000);
        rd(cbp_pkg::ADR_DEV, q);
        chk(q, 32'h0000_0000);
        rd(cbp_pkg::ADR_CNT, q);
        chk(q, 32'h0000_0000);
        rd(fa(4'hc), q);
        chk(q, 32'h0000_0000);
        results();
    end
endmodule // cbp_unit_tb
`default_nettype wire
